/* File: hdl/sltpd_decode.sv */
// Second-level directory-entry decoder with APB register access.
//
// Contract
// - Memory type enable clear means override bit and memory type are ignored.
// - Type fields apply only to nested, PASID, coherent-domain requests.
// - Override bit 0 keeps the attribute table in memory type work.
// - Override bit 1 leaves the attribute table out.
// - Memory type codes 0,1,4,5,6 are defined; others are reserved.
// - Execute denied on a page when exec enable is on and X is 0.
// - Write denied on a page when W is 0.
// - Read denied on a page when R is 0.
// - Zero-length read skips read check if X or W is set.
// - Page size bit 0 means table pointer, 1 means 2-MByte page.
// - Table pointer gives next table base from address width down to 12.
// - Table pointer restricts read, write and execute for its whole region.
// - A leaf entry must carry page size bit 1.
// - Leaf gives page base from address width down to 21.
`timescale 1ns/1ps
module sltpd_decode
  import sltpd_pkg::*;
#(
  parameter int host_address_width = 48
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Interrupt.
  output logic irq
);

  import sltpd_pkg::*;

  localparam logic [63:0] ALL_ONES = 64'hffff_ffff_ffff_ffff;
  localparam logic [63:0] HAW_MASK = ~(ALL_ONES << host_address_width);
  localparam logic [63:0] RSVD_HI_MASK = ~(ALL_ONES << (RSVD_TOP + 1)) & ~HAW_MASK;
  localparam logic [63:0] PTR_ADDR_MASK = HAW_MASK & (ALL_ONES << PTR_ADDR_LSB);
  localparam logic [63:0] LEAF_ADDR_MASK = HAW_MASK & (ALL_ONES << LEAF_ADDR_LSB);
  localparam logic [63:0] LEAF_RSVD_MASK = RSVD_HI_MASK | (PTR_ADDR_MASK & ~LEAF_ADDR_MASK);
  localparam logic [63:0] PTR_RSVD_MASK = RSVD_HI_MASK | (64'h1 << BIT_PTR_RSVD_HI)
    | (64'h1 << BIT_PTR_RSVD_LO);

  // Tells whether a memory type code is defined.
  function automatic logic mtype_known(input logic [2:0] code);
    mtype_known = (code == SLTPD_MT_UC) || (code == SLTPD_MT_WC) || (code == SLTPD_MT_WT)
      || (code == SLTPD_MT_WP) || (code == SLTPD_MT_WB);
  endfunction : mtype_known

  logic [31:0] entry_lo;
  logic [31:0] entry_hi;
  sltpd_ctl_s ctl;
  logic [63:0] page_attribute_table;
  logic start;
  sltpd_res_s res;
  logic [63:0] next_addr_q;
  logic [INT_W-1:0] int_status;
  logic [INT_W-1:0] int_enable;

  wire setup = psel & ~penable;
  wire access = psel & penable & pready;
  wire wr_en = access & pwrite;
  wire sel_entry_lo = (paddr == OFF_ENTRY_LO);
  wire sel_entry_hi = (paddr == OFF_ENTRY_HI);
  wire sel_ctrl = (paddr == OFF_CTRL);
  wire sel_pat_lo = (paddr == OFF_PAT_LO);
  wire sel_pat_hi = (paddr == OFF_PAT_HI);
  wire sel_cmd = (paddr == OFF_CMD);
  wire sel_result = (paddr == OFF_RESULT);
  wire sel_addr_lo = (paddr == OFF_ADDR_LO);
  wire sel_addr_hi = (paddr == OFF_ADDR_HI);
  wire sel_int_stat = (paddr == OFF_INT_STAT);
  wire sel_int_en = (paddr == OFF_INT_EN);
  wire sel_int_clr = (paddr == OFF_INT_CLR);
  wire addr_hit = sel_entry_lo | sel_entry_hi | sel_ctrl | sel_pat_lo | sel_pat_hi
    | sel_cmd | sel_result | sel_addr_lo | sel_addr_hi | sel_int_stat | sel_int_en
    | sel_int_clr;

  wire [31:0] rd_mux =
    sel_entry_lo ? entry_lo :
    sel_entry_hi ? entry_hi :
    sel_ctrl ? {25'h0, ctl} :
    sel_pat_lo ? page_attribute_table[31:0] :
    sel_pat_hi ? page_attribute_table[63:32] :
    sel_result ? {20'h0, res} :
    sel_addr_lo ? next_addr_q[31:0] :
    sel_addr_hi ? next_addr_q[63:32] :
    sel_int_stat ? {30'h0, int_status} :
    sel_int_en ? {30'h0, int_enable} :
    32'h0000_0000;

  // APB answer: one wait-free access phase after each setup.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= RST_WORD;
    end
    else
    begin
      pready <= setup;
      pslverr <= setup & ~addr_hit;
      prdata <= (setup & ~pwrite) ? rd_mux : RST_WORD;
    end
  end

  // Software-written registers.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      entry_lo <= RST_WORD;
      entry_hi <= RST_WORD;
      ctl <= '0;
      page_attribute_table <= RST_PAT;
      start <= 1'b0;
    end
    else
    begin
      if (wr_en & sel_entry_lo)
      begin
        entry_lo <= pwdata;
      end
      if (wr_en & sel_entry_hi)
      begin
        entry_hi <= pwdata;
      end
      if (wr_en & sel_ctrl)
      begin
        ctl <= pwdata[6:0];
      end
      if (wr_en & sel_pat_lo)
      begin
        page_attribute_table[31:0] <= pwdata;
      end
      if (wr_en & sel_pat_hi)
      begin
        page_attribute_table[63:32] <= pwdata;
      end
      start <= wr_en & sel_cmd & pwdata[0];
    end
  end

  wire [63:0] entry = {entry_hi, entry_lo};

  wire is_leaf = entry[BIT_PAGE_SIZE];

  wire exec_ok = ~ctl.second_level_exec_enable | entry[BIT_EXEC];

  wire write_ok = entry[BIT_WRITE];

  wire zlr_skip = ctl.zero_length_read_support & ctl.zero_len
    & (entry[BIT_EXEC] | entry[BIT_WRITE]);

  wire read_ok = entry[BIT_READ] | zlr_skip;

  wire mt_apply = is_leaf & ctl.ext_mem_type_enable & ctl.nested & ctl.pasid
    & ctl.coherent;

  wire [2:0] mtype = mt_apply ? entry[EMT_MSB:EMT_LSB] : SLTPD_MT_UC;
  wire mt_rsvd = mt_apply & ~mtype_known(entry[EMT_MSB:EMT_LSB]);

  wire pat_used = ~(mt_apply & entry[BIT_IGNORE_PAT]);

  wire [63:0] base = entry & (is_leaf ? LEAF_ADDR_MASK : PTR_ADDR_MASK);

  wire rsvd_fault = |(entry & (is_leaf ? LEAF_RSVD_MASK : PTR_RSVD_MASK));
  wire fault = rsvd_fault | mt_rsvd;

  // Results are captured on the cycle after a start command.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      res <= '0;
      next_addr_q <= 64'h0;
    end
    else if (start)
    begin
      res <= '{done: 1'b1, mt_rsvd: mt_rsvd, fault: fault, pat_used: pat_used,
        mt_apply: mt_apply, mtype: mtype, page_2m: is_leaf, exec_ok: exec_ok,
        write_ok: write_ok, read_ok: read_ok};
      next_addr_q <= base;
    end
  end

  sltpd_irq #(
    .W(INT_W)
  ) u_irq (
    .pclk(pclk),
    .presetn(presetn),
    .set({start & fault, start}),
    .clr_wr(wr_en & sel_int_clr),
    .en_wr(wr_en & sel_int_en),
    .wdata(pwdata[INT_W-1:0]),
    .status(int_status),
    .enable(int_enable),
    .irq(irq)
  );

  sequence s_start_leaf;
    start && entry[BIT_PAGE_SIZE];
  endsequence

  sequence s_start_ptr;
    start && !entry[BIT_PAGE_SIZE];
  endsequence

  AST_READ_DENY: assert property (@(posedge pclk) disable iff (!presetn)
    start && !entry[BIT_READ] && !(ctl.zero_length_read_support && ctl.zero_len)
    |=> !res.read_ok)
    else $error("read granted with read bit clear");

  AST_WRITE_DENY: assert property (@(posedge pclk) disable iff (!presetn)
    start && !entry[BIT_WRITE] |=> !res.write_ok && res.done)
    else $error("write granted with write bit clear");

  AST_EXEC_DENY: assert property (@(posedge pclk) disable iff (!presetn)
    start && ctl.second_level_exec_enable && !entry[BIT_EXEC] |=> !res.exec_ok)
    else $error("execute granted with execute bit clear");

  AST_EXEC_FREE: assert property (@(posedge pclk) disable iff (!presetn)
    s_start_ptr ##0 !ctl.second_level_exec_enable |=> res.exec_ok && !res.page_2m)
    else $error("execute denied without execute enable");

  AST_ZLR_SKIP: assert property (@(posedge pclk) disable iff (!presetn)
    start && ctl.zero_length_read_support && ctl.zero_len
    && (entry[BIT_EXEC] || entry[BIT_WRITE]) |=> res.read_ok)
    else $error("zero-length read not exempted");

  AST_EMT_OFF: assert property (@(posedge pclk) disable iff (!presetn)
    start && !ctl.ext_mem_type_enable |=> !res.mt_apply && res.pat_used
    && res.mtype == SLTPD_MT_UC)
    else $error("memory type applied while disabled");

  AST_EMT_SCOPE: assert property (@(posedge pclk) disable iff (!presetn)
    start && !(ctl.nested && ctl.pasid && ctl.coherent) |=> !res.mt_apply)
    else $error("memory type applied outside nested coherent scope");

  AST_PAT_SEL: assert property (@(posedge pclk) disable iff (!presetn)
    s_start_leaf ##0 ctl.ext_mem_type_enable && ctl.nested && ctl.pasid && ctl.coherent
    |=> res.mt_apply && res.pat_used == !$past(entry[BIT_IGNORE_PAT])
    && res.mtype == $past(entry[EMT_MSB:EMT_LSB]))
    else $error("attribute table selection wrong");

  AST_PTR_BASE: assert property (@(posedge pclk) disable iff (!presetn)
    s_start_ptr |=> next_addr_q[PTR_ADDR_LSB-1:0] == 12'h000
    && next_addr_q == ($past(entry) & PTR_ADDR_MASK))
    else $error("table pointer base wrong");

  AST_LEAF_BASE: assert property (@(posedge pclk) disable iff (!presetn)
    s_start_leaf |=> res.page_2m && next_addr_q[LEAF_ADDR_LSB-1:0] == 21'h0
    && next_addr_q == ($past(entry) & LEAF_ADDR_MASK))
    else $error("leaf page base wrong");

  AST_PTR_RSVD: assert property (@(posedge pclk) disable iff (!presetn)
    s_start_ptr ##0 (entry[BIT_PTR_RSVD_HI] || entry[BIT_PTR_RSVD_LO]) |=> res.fault
    && int_status[INT_FAULT])
    else $error("reserved bit not flagged");

  AST_IRQ_DONE: assert property (@(posedge pclk) disable iff (!presetn)
    start && int_enable[INT_DONE] && !(wr_en && sel_int_en) |-> ##[1:2] irq)
    else $error("done interrupt not raised");

  AST_PAGE_SIZE: assert property (@(posedge pclk) disable iff (!presetn)
    start |=> res.page_2m == $past(entry[BIT_PAGE_SIZE]))
    else $error("page size not taken from the entry");

  AST_PTR_NO_EMT: assert property (@(posedge pclk) disable iff (!presetn)
    s_start_ptr |=> !res.mt_apply && !res.page_2m && res.pat_used
    && res.mtype == SLTPD_MT_UC)
    else $error("memory type applied to a table pointer");

  AST_PAT_KEEP: assert property (@(posedge pclk) disable iff (!presetn)
    start && !entry[BIT_IGNORE_PAT] |=> res.pat_used)
    else $error("attribute table dropped with override clear");

  AST_MT_CODE: assert property (@(posedge pclk) disable iff (!presetn)
    start && mt_apply |=> res.mt_rsvd == ((res.mtype == 3'h2) || (res.mtype == 3'h3)
    || (res.mtype == 3'h7)) && (res.fault || !res.mt_rsvd))
    else $error("reserved memory type not flagged");

  AST_LEAF_RSVD: assert property (@(posedge pclk) disable iff (!presetn)
    s_start_leaf ##0 (|entry[LEAF_ADDR_LSB-1:PTR_ADDR_LSB]) |=> res.fault)
    else $error("leaf reserved bits not flagged");

  AST_HI_RSVD: assert property (@(posedge pclk) disable iff (!presetn)
    start && (|entry[RSVD_TOP:host_address_width]) |=> res.fault)
    else $error("upper reserved bits not flagged");

  AST_PTR_IGNORED: assert property (@(posedge pclk) disable iff (!presetn)
    s_start_ptr ##0 (!entry[BIT_PTR_RSVD_HI] && !entry[BIT_PTR_RSVD_LO]
    && !(|entry[RSVD_TOP:host_address_width])) |=> !res.fault)
    else $error("ignored bit raised a fault");

  AST_READ_GRANT: assert property (@(posedge pclk) disable iff (!presetn)
    start && entry[BIT_READ] |=> res.read_ok)
    else $error("read denied with read bit set");

  AST_WRITE_GRANT: assert property (@(posedge pclk) disable iff (!presetn)
    start && entry[BIT_WRITE] |=> res.write_ok)
    else $error("write denied with write bit set");

  AST_EXEC_GRANT: assert property (@(posedge pclk) disable iff (!presetn)
    start && entry[BIT_EXEC] |=> res.exec_ok)
    else $error("execute denied with execute bit set");

  AST_APB_ANSWER: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable |=> pready)
    else $error("setup not answered in the next cycle");

  AST_APB_PULSE: assert property (@(posedge pclk) disable iff (!presetn)
    pready |=> !pready)
    else $error("ready stood longer than one cycle");

  AST_ERR_READY: assert property (@(posedge pclk) disable iff (!presetn)
    pslverr |-> pready)
    else $error("error raised without ready");

  AST_PRDATA_IDLE: assert property (@(posedge pclk) disable iff (!presetn)
    !pready |-> prdata == 32'h0000_0000)
    else $error("read data shown outside an access");

  AST_IRQ_LEVEL: assert property (@(posedge pclk) disable iff (!presetn)
    irq == |(int_status & int_enable))
    else $error("interrupt level differs from enabled status");

endmodule : sltpd_decode

/* File: hdl/sltpd_irq.sv */
// Sticky interrupt status with enable mask and write-one-to-clear.
`timescale 1ns/1ps
module sltpd_irq #(
  parameter int W = 2
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Events and software access.
  input wire logic [W-1:0] set,
  input wire logic clr_wr,
  input wire logic en_wr,
  input wire logic [W-1:0] wdata,
  // State.
  output logic [W-1:0] status,
  output logic [W-1:0] enable,
  output logic irq
);

  logic [W-1:0] clr_mask;
  logic [W-1:0] next_status;

  assign clr_mask = clr_wr ? wdata : '0;
  assign next_status = (status & ~clr_mask) | set;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      status <= '0;
      enable <= '0;
      irq <= 1'b0;
    end
    else
    begin
      status <= next_status;
      if (en_wr)
      begin
        enable <= wdata;
      end
      irq <= |(next_status & (en_wr ? wdata : enable));
    end
  end

endmodule : sltpd_irq

/* File: hdl/sltpd_pkg.sv */
// Package with register map, entry fields and carrier types of the directory-entry decoder.
package sltpd_pkg;

  // Register byte offsets.
  localparam logic [11:0] OFF_ENTRY_LO = 12'h000;
  localparam logic [11:0] OFF_ENTRY_HI = 12'h004;
  localparam logic [11:0] OFF_CTRL = 12'h008;
  localparam logic [11:0] OFF_PAT_LO = 12'h00c;
  localparam logic [11:0] OFF_PAT_HI = 12'h010;
  localparam logic [11:0] OFF_CMD = 12'h014;
  localparam logic [11:0] OFF_RESULT = 12'h018;
  localparam logic [11:0] OFF_ADDR_LO = 12'h01c;
  localparam logic [11:0] OFF_ADDR_HI = 12'h020;
  localparam logic [11:0] OFF_INT_STAT = 12'h024;
  localparam logic [11:0] OFF_INT_EN = 12'h028;
  localparam logic [11:0] OFF_INT_CLR = 12'h02c;

  // Entry field positions.
  localparam int BIT_READ = 0;
  localparam int BIT_WRITE = 1;
  localparam int BIT_EXEC = 2;
  localparam int EMT_LSB = 3;
  localparam int EMT_MSB = 5;
  localparam int BIT_IGNORE_PAT = 6;
  localparam int BIT_PAGE_SIZE = 7;
  localparam int BIT_PTR_RSVD_LO = 11;
  localparam int BIT_PTR_RSVD_HI = 62;
  localparam int PTR_ADDR_LSB = 12;
  localparam int LEAF_ADDR_LSB = 21;
  localparam int RSVD_TOP = 51;

  // Interrupt bits and reset values.
  localparam int INT_W = 2;
  localparam int INT_DONE = 0;
  localparam int INT_FAULT = 1;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [63:0] RST_PAT = 64'h0007_0406_0007_0406;

  // Memory type codes.
  typedef enum logic [2:0] {
    SLTPD_MT_UC = 3'h0,
    SLTPD_MT_WC = 3'h1,
    SLTPD_MT_WT = 3'h4,
    SLTPD_MT_WP = 3'h5,
    SLTPD_MT_WB = 3'h6
  } sltpd_mtype_e;

  // Context controls, top bit first.
  typedef struct packed {
    logic zero_len;
    logic coherent;
    logic pasid;
    logic nested;
    logic zero_length_read_support;
    logic second_level_exec_enable;
    logic ext_mem_type_enable;
  } sltpd_ctl_s;

  // Decode result, top bit first.
  typedef struct packed {
    logic done;
    logic mt_rsvd;
    logic fault;
    logic pat_used;
    logic mt_apply;
    logic [2:0] mtype;
    logic page_2m;
    logic exec_ok;
    logic write_ok;
    logic read_ok;
  } sltpd_res_s;

endpackage : sltpd_pkg

/* File: tb/sltpd_apb_host.sv */
// APB host model that drives the register bus of the decoder.
`timescale 1ns/1ps
module sltpd_apb_host (
  // Clock.
  input wire logic pclk,
  // Bus request.
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  // Bus answer.
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
  end

  // Holds the request until pready is seen high, then releases it.
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
            output logic [31:0] q, output logic e);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
      tb.hang();
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask : xfer
endmodule : sltpd_apb_host

/* File: tb/tb.sv */
// Self-checking testbench of the directory-entry decoder.
`timescale 1ns/1ps
module tb;
  import sltpd_pkg::*;
  localparam int HOST_ADDRESS_WIDTH = 48;
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq;
  int bad_count;
  int compares;

  always #50 pclk = ~pclk;

  sltpd_apb_host m (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  sltpd_decode #(.host_address_width(HOST_ADDRESS_WIDTH)) DUT (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));

  task test_done;
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : test_done

  task hang;
    bad_count++;
    $display("BAD %0t no bus answer", $time);
    test_done();
  endtask : hang

  task chk(input logic [31:0] s, input logic [31:0] x);
    compares++;
    if (s !== x)
    begin
      bad_count++;
      $display("BAD %0t seen %h expected %h", $time, s, x);
    end
  endtask : chk

  task wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    m.xfer(1'b1, a, d, q, e);
  endtask : wr

  task wr_chk(input logic [11:0] a, input logic [31:0] d, input logic xe);
    logic [31:0] q;
    logic e;
    m.xfer(1'b1, a, d, q, e);
    chk({31'h0, e}, {31'h0, xe});
  endtask : wr_chk

  task rd(input logic [11:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] q;
    logic e;
    m.xfer(1'b0, a, 32'h0000_0000, q, e);
    chk(q, x);
    chk({31'h0, e}, {31'h0, xe});
  endtask : rd

  task irq_is(input logic x);
    repeat (3) @(negedge pclk);
    chk({31'h0, irq}, {31'h0, x});
  endtask : irq_is

  function automatic logic [31:0] exp_res(input logic [63:0] e, input logic [6:0] c);
    logic ap;
    logic rs;
    logic flt;
    logic [2:0] mt;
    ap = e[7] & c[0] & c[3] & c[4] & c[5];
    mt = ap ? e[5:3] : 3'h0;
    rs = ap & (e[5:3] inside {3'h2, 3'h3, 3'h7});
    flt = rs | (|e[51:HOST_ADDRESS_WIDTH]) | (e[7] ? |e[20:12] : (e[62] | e[11]));
    exp_res = {20'h0, 1'b1, rs, flt, ~(ap & e[6]), ap, mt, e[7], ~(c[1] & ~e[2]), e[1],
               e[0] | (c[2] & c[6] & (e[2] | e[1]))};
  endfunction : exp_res

  task run(input logic [63:0] e, input logic [6:0] c);
    logic [63:0] ad;
    ad = e & ((64'h1 << HOST_ADDRESS_WIDTH) - 64'h1) & ~((64'h1 << (e[7] ? 21 : 12)) - 64'h1);
    wr(OFF_ENTRY_LO, e[31:0]);
    wr(OFF_ENTRY_HI, e[63:32]);
    wr(OFF_CTRL, {25'h0, c});
    wr(OFF_CMD, 32'h0000_0001);
    rd(OFF_RESULT, exp_res(e, c), 1'b0);
    rd(OFF_ADDR_LO, ad[31:0], 1'b0);
    rd(OFF_ADDR_HI, ad[63:32], 1'b0);
    $display("test done entry %h ctrl %h", e, c);
  endtask : run

  initial
  begin
    pclk = 1'b0;
    presetn = 1'b0;
    bad_count = 0;
    compares = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rd(OFF_PAT_LO, RST_PAT[31:0], 1'b0);
    rd(OFF_PAT_HI, RST_PAT[63:32], 1'b0);
    rd(OFF_RESULT, RST_WORD, 1'b0);
    rd(12'h030, 32'h0000_0000, 1'b1);
    wr(OFF_RESULT, 32'hffff_ffff);
    rd(OFF_RESULT, RST_WORD, 1'b0);
    $display("test done reset values and access kinds");
    for (int i = 0; i < 8; i++)
      run({56'h0, 2'h2, i[2:0], 3'h7}, 7'h3d);
    run(64'h0000_abcd_ee00_00f7, 7'h3f);
    run(64'h0000_abcd_ee00_00f7, 7'h3e);
    run(64'h0000_abcd_ee00_00f7, 7'h35);
    run(64'h0000_0000_0020_0082, 7'h46);
    run(64'h0000_0000_0020_0082, 7'h06);
    run(64'h0000_0000_0020_0080, 7'h44);
    run(64'hbff0_1234_5678_9779, 7'h3b);
    run(64'h4000_0000_0000_1006, 7'h00);
    run(64'h0000_0000_0000_1087, 7'h00);
    run(64'h0001_0000_0020_0083, 7'h00);
    rd(OFF_INT_STAT, 32'h0000_0003, 1'b0);
    irq_is(1'b0);
    wr(OFF_INT_EN, 32'h0000_0002);
    irq_is(1'b1);
    rd(OFF_INT_EN, 32'h0000_0002, 1'b0);
    wr(OFF_INT_CLR, 32'h0000_0002);
    rd(OFF_INT_STAT, 32'h0000_0001, 1'b0);
    irq_is(1'b0);
    wr(OFF_INT_EN, 32'h0000_0001);
    irq_is(1'b1);
    wr(OFF_INT_CLR, 32'h0000_0001);
    irq_is(1'b0);
    run(64'h0000_0000_0020_0083, 7'h00);
    irq_is(1'b1);
    $display("test done interrupt set mask clear");
    wr(OFF_ENTRY_LO, 32'h0000_0000);
    wr(OFF_CMD, 32'h0000_0002);
    rd(OFF_RESULT, exp_res(64'h0000_0000_0020_0083, 7'h00), 1'b0);
    rd(OFF_ADDR_LO, 32'h0020_0000, 1'b0);
    wr_chk(OFF_PAT_LO, 32'h0605_0401, 1'b0);
    wr_chk(OFF_PAT_HI, 32'h0007_0504, 1'b0);
    wr_chk(12'h030, 32'hffff_ffff, 1'b1);
    rd(OFF_PAT_LO, 32'h0605_0401, 1'b0);
    rd(OFF_PAT_HI, 32'h0007_0504, 1'b0);
    $display("test done command bits and attribute table");
    @(posedge pclk);
    presetn <= 1'b0;
    irq_is(1'b0);
    @(posedge pclk);
    presetn <= 1'b1;
    rd(OFF_PAT_LO, RST_PAT[31:0], 1'b0);
    rd(OFF_PAT_HI, RST_PAT[63:32], 1'b0);
    rd(OFF_RESULT, RST_WORD, 1'b0);
    rd(OFF_INT_STAT, RST_WORD, 1'b0);
    rd(OFF_INT_EN, RST_WORD, 1'b0);
    $display("test done reset in mid-run");
    test_done();
  end
endmodule : tb
